// file: bench/scp_capture_tb.sv
// self-checking bench for the state capture clocking block
`timescale 1ns/1ps
module scp_capture_tb;
  import scp_pkg::*;
  logic         hclk = 1'b0;
  logic         link_clk = 1'b0;
  logic         hresetn, hsel, hwrite, hreadyout, hresp, cap_strobe;
  logic [31:0]  haddr, hwdata, hrdata, pod_setup_sel;
  logic [1:0]   htrans, extra_line;
  logic [2:0]   hsize;
  logic [5:0]   clk_line;
  logic [3:0]   gating_term;
  logic [127:0] pod_data, cap_data, exp;
  logic [7:0]   cap_clk, trig_clk_bits;
  int           n_errors = 0;
  int           check_count = 0;
  int           n_strobe = 0;

  // ------------------------------------------------------------
  // clocks, strobe counter, instances
  // ------------------------------------------------------------
  always #2.5 hclk = ~hclk;
  // link clock offset so the domains never line up
  initial begin
    #1.7;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge link_clk) if (cap_strobe === 1'b1) n_strobe++;

  scp_capture #(.NPODS(8), .POD_W(16)) u_scp_capture (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pod_setup_sel(pod_setup_sel),
    .link_clk(link_clk), .clk_line(clk_line), .extra_line(extra_line),
    .gating_term(gating_term), .pod_data(pod_data), .cap_strobe(cap_strobe),
    .cap_data(cap_data), .cap_clk(cap_clk), .trig_clk_bits(trig_clk_bits));
  scp_target u_scp_target (.hclk(hclk), .clk_line(clk_line), .extra_line(extra_line),
    .gating_term(gating_term), .pod_data(pod_data));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] e);
    check_count++;
    if (seen !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, seen);
    end
  endtask

  // one single AHB transfer; waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    chk("hready_addr", {127'h0, hreadyout}, 128'h1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    rd = hrdata;
    chk("hready_data", {127'h0, hreadyout}, 128'h1);
    chk("hresp", {127'h0, hresp}, 128'h0);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h00000000, r);
    chk(what, {96'h0, r}, {96'h0, e});
  endtask

  // config write, then poll the pending flag until the link side took it
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    int n;
    bus(a, 1'b1, d, r);
    r = 32'h00000001;
    n = 0;
    while (r[0] !== 1'b0 && n++ < 40) bus(OFS_STATUS, 1'b0, 32'h00000000, r);
    chk("pending", {127'h0, r[0]}, 128'h0);
    repeat (10) @(posedge link_clk);
  endtask

  // one target pulse and the number of strobes it must cause
  task automatic ev(input int line, input logic [127:0] d, input int n_exp);
    int n0;
    n0 = n_strobe;
    u_scp_target.pulse(line, d);
    repeat (4) @(posedge link_clk);
    chk("strobes", 128'(n_strobe - n0), 128'(n_exp));
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    rchk("master_arr", OFS_MASTER, {10'h000, ARR_RST});
    rchk("slave_arr", OFS_SLAVE, {10'h000, ARR_RST});
    rchk("roles", OFS_ROLE, ROLE_RST);
    rchk("setup", OFS_SETUP, SETUP_RST);
    rchk("status", OFS_STATUS, 32'h00000000);
    bus(8'h20, 1'b1, 32'hFFFFFFFF, r);
    rchk("unmapped", 8'h20, 32'h00000000);
    $display("test reset done");
  endtask

  // unused clock lines show up as trigger data bits, extra lines always
  task automatic t_trig();
    u_scp_target.extras(2'h1);
    u_scp_target.levels(6'h3E);
    repeat (10) @(posedge link_clk);
    chk("trig_bits", {120'h0, trig_clk_bits}, {120'h0, 2'h1, 6'h3E});
    u_scp_target.extras(2'h2);
    u_scp_target.levels(6'h00);
    repeat (10) @(posedge link_clk);
    chk("trig_extra", {126'h0, trig_clk_bits[7:6]}, 128'h2);
    $display("test trig done");
  endtask

  task automatic t_master();
    ev(0, 128'h0123456789ABCDEF_FEDCBA9876543210, 1);
    chk("cap_data", cap_data, 128'h0123456789ABCDEF_FEDCBA9876543210);
    chk("cap_clk_extra", {126'h0, cap_clk[5:4]}, 128'h2);
    ev(1, 128'h5, 0);
    u_scp_target.levels(6'h3E);
    repeat (10) @(posedge link_clk);
    u_scp_target.levels(6'h00);
    $display("test master done");
  endtask

  // two slave latches before the master strobe, then a master strobe alone
  task automatic t_slave();
    cfg(OFS_SLAVE, 32'h00000002);
    cfg(OFS_ROLE, 32'h00000004);
    rchk("roles_back", OFS_ROLE, 32'h00000004);
    ev(1, 128'hAAAA1111_AAAA1111_AAAA1111_AAAA1111, 0);
    ev(1, 128'hBBBB2222_BBBB2222_BBBB2222_BBBB3333, 0);
    ev(0, 128'hCCCC4444_CCCC4444_CCCC4444_CCCC5555, 1);
    exp = 128'hCCCC4444_CCCC4444_CCCC4444_BBBB5555;
    chk("slave_cap", cap_data, exp);
    ev(0, 128'hDDDD6666_DDDD6666_DDDD6666_DDDD7777, 1);
    chk("slave_kept", cap_data, 128'hDDDD6666_DDDD6666_DDDD6666_BBBB7777);
    $display("test slave done");
  endtask

  task automatic t_demux();
    cfg(OFS_ROLE, 32'h00000002);
    ev(1, 128'h1, 0);
    ev(1, 128'h9999, 0);
    ev(0, 128'hEEEE8888_EEEE8888_EEEE8888_EEEE4321, 1);
    chk("demux_cap", cap_data, 128'hEEEE8888_EEEE8888_EEEE8888_99994321);
    cfg(OFS_ROLE, 32'h00000000);
    $display("test demux done");
  endtask

  // halves pair lines 0-2 with terms 1,2 and lines 3-5 with terms 3,4
  task automatic t_qual();
    cfg(OFS_MASTER, 32'h00055009);
    u_scp_target.terms(4'h0);
    ev(0, 128'h7, 0);
    u_scp_target.terms(4'h1);
    ev(0, 128'h7, 1);
    ev(3, 128'h8, 0);
    u_scp_target.terms(4'h4);
    ev(3, 128'h8, 1);
    cfg(OFS_MASTER, 32'h00033001);
    u_scp_target.terms(4'h2);
    ev(0, 128'h9, 0);
    cfg(OFS_MASTER, 32'h00133001);
    ev(0, 128'h9, 1);
    u_scp_target.terms(4'h0);
    $display("test qual done");
  endtask

  // requested point is clamped to the span of the selected edges
  task automatic t_span();
    // span counts the union of both arrangements: slave back on line 0 rise
    cfg(OFS_SLAVE, 32'h00000001);
    cfg(OFS_MASTER, 32'h00000001);
    cfg(OFS_SETUP, 32'hFFFFFFFF);
    repeat (20) @(posedge hclk);
    chk("span_one", {96'h0, pod_setup_sel}, {96'h0, {8{SEL_ONE}}});
    cfg(OFS_MASTER, 32'h00000041);
    repeat (20) @(posedge hclk);
    chk("span_both", {96'h0, pod_setup_sel}, {96'h0, {8{SEL_BOTH}}});
    cfg(OFS_MASTER, 32'h00000003);
    repeat (20) @(posedge hclk);
    chk("span_multi", {96'h0, pod_setup_sel}, {96'h0, {8{SEL_MULTI}}});
    $display("test span done");
  endtask

  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // whole run needs some 6 us; the limit leaves ample room
  initial begin
    #60000;
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge link_clk);
    t_reset();
    t_trig();
    t_master();
    t_slave();
    t_demux();
    t_qual();
    t_span();
    finish_test();
  end
endmodule

// file: bench/scp_target.sv
// target system model: clock lines, gating terms and pod data
`timescale 1ns/1ps
module scp_target (
  input  wire logic    hclk,
  output logic [5:0]   clk_line,
  output logic [1:0]   extra_line,
  output logic [3:0]   gating_term,
  output logic [127:0] pod_data
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  initial begin
    clk_line    = 6'h00;
    extra_line  = 2'h2;
    gating_term = 4'h0;
    pod_data    = 128'h0;
  end

  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  // one pulse, data held 30 ns round the rising edge, then flipped so a
  // late sample can never match by luck; hclk edges never meet link_clk edges
  task automatic pulse(input int line, input logic [127:0] d);
    @(posedge hclk);
    pod_data <= d;
    repeat (6) @(posedge hclk);
    clk_line[line] <= 1'b1;
    repeat (6) @(posedge hclk);
    pod_data <= ~d;
    repeat (6) @(posedge hclk);
    clk_line[line] <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  // qualifier levels are plain levels, no edge meaning
  task automatic terms(input logic [3:0] t);
    @(posedge hclk);
    gating_term <= t;
  endtask

  // static clock line levels for the trigger bit check
  task automatic levels(input logic [5:0] v);
    @(posedge hclk);
    clk_line <= v;
  endtask

  // extra lines beyond the six clocks, data only
  task automatic extras(input logic [1:0] v);
    @(posedge hclk);
    extra_line <= v;
  endtask
endmodule

// file: hdl/scp_capture.sv
// state capture clocking front end with an AHB-Lite register slave
`timescale 1ns/1ps
// Function
// - clock lines 0,1 go with pod pair 1/2, lines 2,3 with pair 3/4, lines 4,5 with the last pair.
// - clock lines beyond the six master-capable ones serve only as data, never as clocks.
// - a clock line used by no arrangement is a trigger data bit, but never feeds the range comparator.
// - each pod takes exactly one role in state mode: master, slave or demultiplex.
// - a master arrangement match writes the current data of every master pod into memory.
// - a slave match latches a slave pod's data; the next master match stores it with master data.
// - several slave matches between master matches overwrite; only the last is stored.
// - demultiplex samples only one pod of the pair and presents primary and secondary groups.
// - in demultiplex a slave match latches secondary data, stored with primary at the next master match.
// - an arrangement offers up to six clock lines and up to four gating terms.
// - clock edges are ORed, gated by qualifier levels with AND; qualifiers combine by AND or OR.
// - the arrangement is two halves ORed: lines 0-2 with terms 1,2 and lines 3-5 with terms 3,4.
// - each pod's sampling point is set apart; span 3.5 ns one edge, 4.0 ns both edges, 4.5 ns more.
module scp_capture #(
  parameter int NPODS = 8,
  parameter int POD_W = 16
) (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic [31:0]                            hrdata,
  output logic                                   hresp,
  output logic [NPODS*scp_pkg::SEL_W-1:0]        pod_setup_sel,
  input  wire logic                              link_clk,
  input  wire logic [scp_pkg::NCLK-1:0]          clk_line,
  input  wire logic [NPODS-6-1:0]                extra_line,
  input  wire logic [scp_pkg::NQUAL-1:0]         gating_term,
  input  wire logic [NPODS*POD_W-1:0]            pod_data,
  output logic                                   cap_strobe,
  output logic [NPODS*POD_W-1:0]                 cap_data,
  output logic [NPODS-1:0]                       cap_clk,
  output logic [scp_pkg::NCLK+NPODS-6-1:0]       trig_clk_bits
);
  import scp_pkg::*;

  localparam int NX = NPODS - 6;
  localparam int DW = NPODS * POD_W;
  localparam int RW = 2 * NPODS;
  localparam int SW = NPODS * SEL_W;

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ARR_W-1:0] marr;
    logic [ARR_W-1:0] sarr;
    logic [RW-1:0]    roles;
    logic [SW-1:0]    shsel;
    logic [SW-1:0]    setup;
    logic             req;
    logic             a1;
    logic             a2;
    logic [CNT_W-1:0] g1;
    logic [CNT_W-1:0] g2;
    logic             awr;
    logic [7:0]       aaddr;
    logic [31:0]      rdata;
    logic             rdy;
  } scp_bus_type;

  typedef struct packed {
    logic [NCLK-1:0]  c1;
    logic [NCLK-1:0]  c2;
    logic [NCLK-1:0]  c3;
    logic [NQUAL-1:0] q1;
    logic [NQUAL-1:0] q2;
    logic [NX-1:0]    x1;
    logic [NX-1:0]    x2;
    logic [DW-1:0]    d1;
    logic [DW-1:0]    d2;
    logic [2:0]       req;
    logic             ack;
    logic [ARR_W-1:0] marr;
    logic [ARR_W-1:0] sarr;
    logic [RW-1:0]    roles;
    logic [DW-1:0]    hold;
    logic             stb;
    logic [DW-1:0]    cap;
    logic [NPODS-1:0] cclk;
    logic [NCLK+NX-1:0] trig;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gray;
  } scp_link_type;

  scp_bus_type  r;
  scp_bus_type  next_r;
  scp_link_type l;
  scp_link_type next_l;
  logic [1:0]   lrs;
  logic         lrst_n;
  logic         mhit;
  logic         shit;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one half: any selected edge of its three lines, gated by its two terms
  function automatic logic half_hit(input logic [2:0] e, input logic [1:0] en,
                                    input logic [1:0] m, input logic use_or);
    logic qual;
    if (use_or) begin
      qual = (en[0] & m[0]) | (en[1] & m[1]) | ~(en[0] | en[1]);
    end else begin
      qual = (~en[0] | m[0]) & (~en[1] | m[1]);
    end
    return (|e) & qual;
  endfunction

  // full arrangement: six lines, four gating terms
  function automatic logic arr_hit(input logic [ARR_W-1:0] a, input logic [NCLK-1:0] rise,
                                   input logic [NCLK-1:0] fall, input logic [NQUAL-1:0] q);
    logic [NCLK-1:0]  e;
    logic [NQUAL-1:0] m;
    logic [NQUAL-1:0] en;
    e  = (a[F_RISE +: NCLK] & rise) | (a[F_FALL +: NCLK] & fall);
    en = a[F_QEN +: NQUAL];
    m  = ~(q ^ a[F_QLVL +: NQUAL]);
    return half_hit(e[2:0], en[1:0], m[1:0], a[F_QOR_A])
         | half_hit(e[5:3], en[3:2], m[3:2], a[F_QOR_B]);
  endfunction

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ------------------------------------------------------------
  // bus side: register file and config handshake
  // ------------------------------------------------------------
  // next state of the bus domain; writes land before the read mux so back-to-back
  // write then read returns the new value
  always_comb begin
    logic [NCLK-1:0]  edges;
    logic [NCLK-1:0]  lines;
    logic [3:0]       nedge;
    logic [3:0]       nline;
    logic [SEL_W-1:0] lim;
    logic [SEL_W-1:0] want;
    logic [7:0]       ofs;
    edges = '0;
    lines = '0;
    nedge = '0;
    nline = '0;
    lim   = '0;
    want  = '0;
    ofs   = '0;
    next_r = r;
    next_r.g1 = l.gray;
    next_r.g2 = r.g1;
    next_r.a1 = l.ack;
    next_r.a2 = r.a1;
    next_r.rdy = 1'b1;
    // data phase of a write
    if (r.awr) begin
      unique case (r.aaddr)
        OFS_MASTER: begin
          next_r.marr = hwdata[ARR_W-1:0];
          next_r.req  = ~r.req;
        end
        OFS_SLAVE: begin
          next_r.sarr = hwdata[ARR_W-1:0];
          next_r.req  = ~r.req;
        end
        OFS_ROLE: begin
          next_r.roles = hwdata[RW-1:0];
          next_r.req   = ~r.req;
        end
        OFS_SETUP: begin
          next_r.shsel = hwdata[SW-1:0];
        end
        default: begin
        end
      endcase
    end
    // address phase
    next_r.awr   = 1'b0;
    next_r.rdata = '0;
    if (hsel && hready && htrans[1]) begin
      ofs = (haddr[31:8] == '0) ? haddr[7:0] : OFS_NONE;
      next_r.awr   = hwrite;
      next_r.aaddr = ofs;
      if (!hwrite) begin
        unique case (ofs)
          OFS_MASTER: next_r.rdata = 32'(next_r.marr);
          OFS_SLAVE:  next_r.rdata = 32'(next_r.sarr);
          OFS_ROLE:   next_r.rdata = 32'(next_r.roles);
          OFS_SETUP:  next_r.rdata = 32'(next_r.shsel);
          OFS_STATUS: begin
            next_r.rdata[F_PEND] = next_r.req ^ r.a2;
            next_r.rdata[F_COUNT +: CNT_W] = gray2bin(r.g2);
          end
          default:    next_r.rdata = '0;
        endcase
      end
    end
    // span limit from the edges that the arrangements use
    edges = next_r.marr[F_RISE +: NCLK] | next_r.sarr[F_RISE +: NCLK];
    lines = edges | next_r.marr[F_FALL +: NCLK] | next_r.sarr[F_FALL +: NCLK];
    for (int i = 0; i < NCLK; i++) begin
      nedge = nedge + 4'(edges[i])
            + 4'(next_r.marr[F_FALL+i] | next_r.sarr[F_FALL+i]);
      nline = nline + 4'(lines[i]);
    end
    if (nedge <= 4'h1) begin
      lim = SEL_ONE;
    end else if (nline == 4'h1) begin
      lim = SEL_BOTH;
    end else begin
      lim = SEL_MULTI;
    end
    // each pod clamped on its own
    for (int p = 0; p < NPODS; p++) begin
      want = next_r.shsel[p*SEL_W +: SEL_W];
      next_r.setup[p*SEL_W +: SEL_W] = (want > lim) ? lim : want;
    end
  end

  // bus domain registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r       <= '0;
      r.marr  <= ARR_RST;
      r.sarr  <= ARR_RST;
      r.roles <= ROLE_RST[RW-1:0];
      r.shsel <= SETUP_RST[SW-1:0];
      r.rdy   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout     = r.rdy;
  assign hrdata        = r.rdata;
  assign hresp         = 1'b0;
  assign pod_setup_sel = r.setup;

  // ------------------------------------------------------------
  // link side reset release
  // ------------------------------------------------------------
  // asserts at once, releases on link_clk so no flop sees a runt release
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      lrs <= 2'b00;
    end else begin
      lrs <= {lrs[0], 1'b1};
    end
  end
  assign lrst_n = lrs[1];

  // ------------------------------------------------------------
  // link side: edge detect, arrangements, slave hold, strobe
  // ------------------------------------------------------------
  // clock pins pass three flops, data pins two; edges come from the second and third
  // stage so the data sample in stage two lines up with the edge it belongs to
  always_comb begin
    logic [NCLK-1:0]  rise;
    logic [NCLK-1:0]  fall;
    logic [NCLK-1:0]  used;
    logic [1:0]       re;
    logic [1:0]       rp;
    logic [POD_W-1:0] fresh;
    int               e;
    rise  = l.c2 & ~l.c3;
    fall  = ~l.c2 & l.c3;
    used  = '0;
    re    = '0;
    rp    = '0;
    fresh = '0;
    e     = 0;
    next_l = l;
    next_l.c1 = clk_line;
    next_l.c2 = l.c1;
    next_l.c3 = l.c2;
    next_l.q1 = gating_term;
    next_l.q2 = l.q1;
    next_l.x1 = extra_line;
    next_l.x2 = l.x1;
    next_l.d1 = pod_data;
    next_l.d2 = l.d1;
    next_l.req = {l.req[1:0], r.req};
    // bus config is stable while the toggle is in flight
    if (l.req[2] != l.req[1]) begin
      next_l.marr  = r.marr;
      next_l.sarr  = r.sarr;
      next_l.roles = r.roles;
      next_l.ack   = l.req[1];
    end
    mhit = arr_hit(l.marr, rise, fall, l.q2);
    shit = arr_hit(l.sarr, rise, fall, l.q2);
    // lines used by neither arrangement feed the trigger terms only
    used = l.marr[F_RISE +: NCLK] | l.marr[F_FALL +: NCLK]
         | l.sarr[F_RISE +: NCLK] | l.sarr[F_FALL +: NCLK];
    next_l.trig = {l.x2, l.c2 & ~used};
    next_l.stb  = 1'b0;
    // slave and demux pods latch; a newer match overwrites
    for (int p = 0; p < NPODS; p++) begin
      rp = l.roles[2*p +: 2];
      if (shit && (rp == SCP_SLAVE || rp == SCP_DEMUX)) begin
        next_l.hold[p*POD_W +: POD_W] = l.d2[p*POD_W +: POD_W];
      end
    end
    if (mhit) begin
      next_l.stb = 1'b1;
      next_l.cnt = l.cnt + 1'b1;
      for (int p = 0; p < NPODS; p++) begin
        e  = p - (p % 2);
        re = l.roles[2*e +: 2];
        rp = l.roles[2*p +: 2];
        if (re == SCP_DEMUX) begin
          // only the even pod is sampled; odd slot carries the secondary group
          fresh = shit ? l.d2[e*POD_W +: POD_W] : l.hold[e*POD_W +: POD_W];
          next_l.cap[p*POD_W +: POD_W] = (p == e) ? l.d2[e*POD_W +: POD_W] : fresh;
        end else begin
          fresh = shit ? l.d2[p*POD_W +: POD_W] : l.hold[p*POD_W +: POD_W];
          unique case (rp)
            SCP_MASTER: next_l.cap[p*POD_W +: POD_W] = l.d2[p*POD_W +: POD_W];
            SCP_SLAVE:  next_l.cap[p*POD_W +: POD_W] = fresh;
            default:    next_l.cap[p*POD_W +: POD_W] = '0;
          endcase
        end
      end
      // clock line levels stored beside their pod pair
      next_l.cclk[1:0] = l.c2[1:0];
      next_l.cclk[3:2] = l.c2[3:2];
      next_l.cclk[NPODS-1 -: 2] = l.c2[5:4];
      for (int k = 4; k < NPODS - 2; k++) begin
        next_l.cclk[k] = l.x2[k-4];
      end
    end
    next_l.gray = l.cnt ^ (l.cnt >> 1);
  end

  // link domain registers
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l      <= '0;
      l.marr <= ARR_RST;
      l.sarr <= ARR_RST;
    end else begin
      l <= next_l;
    end
  end

  assign cap_strobe    = l.stb;
  assign cap_data      = l.cap;
  assign cap_clk       = l.cclk;
  assign trig_clk_bits = l.trig;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence seq_master_stored;
    mhit ##1 cap_strobe;
  endsequence

  sequence seq_slave_latched;
    shit && l.roles[3:2] == SCP_SLAVE && l.req[2] == l.req[1];
  endsequence

  property prop_strobe;
    @(posedge link_clk) disable iff (!lrst_n) mhit |-> seq_master_stored;
  endproperty

  AST_STROBE_ON_MATCH: assert property (prop_strobe)
    else $error("master match gave no capture strobe");

  AST_NO_STROBE_IDLE: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !mhit |=> !cap_strobe)
    else $error("capture strobe without master match");

  AST_MASTER_DATA: assert property (@(posedge link_clk) disable iff (!lrst_n)
    mhit && l.roles[1:0] == SCP_MASTER |=> cap_data[POD_W-1:0] == $past(l.d2[POD_W-1:0]))
    else $error("master pod data not stored");

  AST_SLAVE_LATCH: assert property (@(posedge link_clk) disable iff (!lrst_n)
    seq_slave_latched |=> l.hold[2*POD_W-1:POD_W] == $past(l.d2[2*POD_W-1:POD_W]))
    else $error("slave pod not latched");

  AST_HOLD_KEEP: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !shit ##1 !shit |=> $stable(l.hold))
    else $error("hold register changed without slave match");

  AST_SLAVE_STORE: assert property (@(posedge link_clk) disable iff (!lrst_n)
    mhit && !shit && l.roles[3:2] == SCP_SLAVE && l.roles[1:0] != SCP_DEMUX
    |=> cap_data[2*POD_W-1:POD_W] == $past(l.hold[2*POD_W-1:POD_W]))
    else $error("held slave data not stored");

  AST_DEMUX_PAIR: assert property (@(posedge link_clk) disable iff (!lrst_n)
    mhit && !shit && l.roles[1:0] == SCP_DEMUX
    |=> cap_data[2*POD_W-1:POD_W] == $past(l.hold[POD_W-1:0])
        && cap_data[POD_W-1:0] == $past(l.d2[POD_W-1:0]))
    else $error("demux groups wrong");

  AST_CLK_PAIR: assert property (@(posedge link_clk) disable iff (!lrst_n)
    mhit |=> cap_clk[1:0] == $past(l.c2[1:0]) && cap_clk[NPODS-1 -: 2] == $past(l.c2[5:4]))
    else $error("clock lines stored with wrong pair");

  AST_TRIG_USED: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (l.marr[F_RISE] | l.marr[F_FALL]) && $stable(l.marr) |=> !trig_clk_bits[0])
    else $error("used clock line offered as data");

  AST_SETUP_SPAN: assert property (@(posedge hclk) disable iff (!hresetn)
    pod_setup_sel[SEL_W-1:0] <= SEL_MULTI)
    else $error("setup selector beyond span");

endmodule

// file: hdl/scp_pkg.sv
// constants and types shared by the state capture clocking block
package scp_pkg;

  // ------------------------------------------------------------
  // clock lines and gating terms
  // ------------------------------------------------------------
  localparam int NCLK  = 6;
  localparam int NQUAL = 4;
  localparam int CNT_W = 8;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_MASTER = 8'h00;
  localparam logic [7:0] OFS_SLAVE  = 8'h04;
  localparam logic [7:0] OFS_ROLE   = 8'h08;
  localparam logic [7:0] OFS_SETUP  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_NONE   = 8'hFF;

  // ------------------------------------------------------------
  // arrangement word layout
  // ------------------------------------------------------------
  localparam int ARR_W    = 22;
  localparam int F_RISE   = 0;
  localparam int F_FALL   = 6;
  localparam int F_QEN    = 12;
  localparam int F_QLVL   = 16;
  localparam int F_QOR_A  = 20;
  localparam int F_QOR_B  = 21;
  localparam int F_PEND   = 0;
  localparam int F_COUNT  = 8;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [ARR_W-1:0] ARR_RST = 22'h000001;
  localparam logic [31:0] ROLE_RST  = 32'h00000000;
  localparam logic [31:0] SETUP_RST = 32'h00000000;

  // ------------------------------------------------------------
  // setup/hold span, in ps, and selector limits
  // ------------------------------------------------------------
  localparam int SH_STEP_PS    = 500;
  localparam int SPAN_ONE_PS   = 3500;
  localparam int SPAN_BOTH_PS  = 4000;
  localparam int SPAN_MULTI_PS = 4500;
  localparam int SEL_W         = 4;
  localparam logic [SEL_W-1:0] SEL_ONE   = SEL_W'(SPAN_ONE_PS / SH_STEP_PS);
  localparam logic [SEL_W-1:0] SEL_BOTH  = SEL_W'(SPAN_BOTH_PS / SH_STEP_PS);
  localparam logic [SEL_W-1:0] SEL_MULTI = SEL_W'(SPAN_MULTI_PS / SH_STEP_PS);

  // pod clocking roles
  typedef enum logic [1:0] {
    SCP_MASTER = 2'b00,
    SCP_SLAVE  = 2'b01,
    SCP_DEMUX  = 2'b10,
    SCP_OFF    = 2'b11
  } scp_role_type;

endpackage
